// File: rtl/ncw_config_bank.sv
// Purpose: Nonvolatile configuration word bank with reset-time latching
// Assumes: Table-read and programming ports are on the MCLK_I domain
// Notes:   Word storage is not touched by reset, only by programming
//
// Functional notes
// [RULE_01] Each word is 24 bits wide and only the low 16 bits hold settings.
// [RULE_02] A programmed bit reads zero and an unprogrammed (erased) bit reads one.
// [RULE_03] Words sit from the configuration base upward and stay readable in normal running.
// [RULE_04] Unimplemented bit positions, including all above the fields, read as zero.
// [RULE_05] Words are written by self-programming firmware, the serial programmer or a device programmer.
// [RULE_06] Protection level 11 is none, 10 is standard and 0x is high security.
// [RULE_07] The general write-protect bit allows general segment writes at 1 and blocks them at 0.
// [RULE_08] With two-speed start-up at 1 the device starts on fast RC, then moves to the chosen source.
// [RULE_09] A three-bit field chooses the initial oscillator source.
// [RULE_10] The second oscillator pin function bit gives clock output at 1 and digital I/O at 0.
// [RULE_11] Primary mode 11 is off, 10 high-speed crystal, 01 standard crystal, 00 external clock.
// [RULE_12] The alternate two-wire bit selects primary pins at 1 and alternate pins at 0.
// [RULE_13] All fields are latched during reset and held stable until the next reset.
`timescale 1ns/1ns

module ncw_config_bank
  import ncw_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              NRST_I,
  // Table-read port
  input  wire logic              RD_EN_I,
  input  wire logic [ADDR_W-1:0] RD_ADDR_I,
  output logic      [WORD_W-1:0] RD_DATA_O,
  output logic                   RD_VALID_O,
  // Programming port
  input  wire logic              WR_EN_I,
  input  wire logic [ADDR_W-1:0] WR_ADDR_I,
  input  wire logic [WORD_W-1:0] WR_DATA_I,
  input  wire logic              ERASE_I,
  output logic                   WR_DONE_O,
  // Code protection controls
  output logic [1:0]             GEN_PROTECT_LEVEL_O,
  output logic                   GEN_PROT_NONE_O,
  output logic                   GEN_PROT_STANDARD_O,
  output logic                   GEN_PROT_HIGH_O,
  output logic                   GEN_WRITE_ALLOW_O,
  // Oscillator controls
  output logic                   TWO_SPEED_STARTUP_O,
  output logic                   START_ON_FAST_RC_O,
  output logic [2:0]             INIT_CLOCK_SOURCE_O,
  output logic                   INIT_USES_PLL_O,
  output logic                   SECOND_OSCILLATOR_PIN_CLOCK_OUT_O,
  output logic [1:0]             PRIMARY_OSC_MODE_O,
  output logic                   PRIMARY_OSC_ENABLE_O,
  // Pin mapping
  output logic                   TWO_WIRE_ALT_SEL_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Implemented-bit mask of one word, zero for an unmapped index
  function automatic logic [WORD_W-1:0] word_mask(input logic [IDX_W-1:0] idx);
    logic [WORD_W-1:0] m;
    m = '0;
    unique case (idx)
      IDX_BOOT:   m = MASK_BOOT;
      IDX_SECURE: m = MASK_SECURE;
      IDX_GEN:    m = MASK_GEN;
      IDX_OSCSEL: m = MASK_OSCSEL;
      IDX_OSC:    m = MASK_OSC;
      IDX_WDOG:   m = MASK_WDOG;
      IDX_POR:    m = MASK_POR;
      default:    m = '0;
    endcase
    return m & MASK_CFG;
  endfunction

  // Address to word index; hit low when outside the bank
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - CFG_BASE;
    return (a >= CFG_BASE) && (off[0] == 1'b0) && (off < ADDR_W'(NUM_WORDS) * ADDR_STEP);
  endfunction

  function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - CFG_BASE;
    return off[IDX_W:1];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile storage

  // Starts erased: every implemented bit unprogrammed
  logic [WORD_W-1:0] cfg_mem [NUM_WORDS] = '{MASK_BOOT, MASK_SECURE, MASK_GEN, MASK_OSCSEL,
                                             MASK_OSC, MASK_WDOG, MASK_POR};

  logic              wr_hit;
  logic [IDX_W-1:0]  wr_idx;
  logic              rd_hit;
  logic [IDX_W-1:0]  rd_idx;

  assign wr_hit = addr_hit(WR_ADDR_I);
  assign wr_idx = addr_idx(WR_ADDR_I);
  assign rd_hit = addr_hit(RD_ADDR_I);
  assign rd_idx = addr_idx(RD_ADDR_I);

  // [RULE_05] programming port writes
  // [RULE_02] erase returns bits to one
  // Erase wins over a same-cycle write; only implemented bits are stored
  always_ff @(posedge MCLK_I)
  begin
    if (ERASE_I)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        cfg_mem[i] <= word_mask(IDX_W'(i));
      end
    end
    else if (WR_EN_I && wr_hit)
    begin
      cfg_mem[wr_idx] <= WR_DATA_I & word_mask(wr_idx);
    end
  end

  // Write completion pulse, one cycle after the accepted request
  logic wr_done_ff;

  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
      wr_done_ff <= 1'b0;
    else
      wr_done_ff <= ERASE_I | (WR_EN_I & wr_hit);
  end

  assign WR_DONE_O = wr_done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Table-read path

  logic [WORD_W-1:0] rd_data_ff;
  logic              rd_valid_ff;
  logic [WORD_W-1:0] nxt_rd_data;

  // [RULE_01] [RULE_04] upper byte and unused bits zero
  always_comb
  begin
    nxt_rd_data = rd_data_ff;
    if (RD_EN_I)
      nxt_rd_data = rd_hit ? (cfg_mem[rd_idx] & word_mask(rd_idx)) : '0;
  end

  // [RULE_03] readable in normal running
  // Unmapped reads still answer, with zero, so firmware never stalls
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= RD_EN_I;
    end
  end

  assign RD_DATA_O  = rd_data_ff;
  assign RD_VALID_O = rd_valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset-time latch of the decoded settings

  logic [1:0] gen_prot_ff;
  logic       gen_none_ff;
  logic       gen_std_ff;
  logic       gen_high_ff;
  logic       gen_wr_ff;
  logic       two_speed_ff;
  logic       fast_rc_ff;
  logic [2:0] src_ff;
  logic       src_pll_ff;
  logic       second_oscillator_pin_ff;
  logic [1:0] posc_ff;
  logic       posc_en_ff;
  logic       alt_tw_ff;

  logic [WORD_W-1:0] w_gen;
  logic [WORD_W-1:0] w_sel;
  logic [WORD_W-1:0] w_osc;
  logic [WORD_W-1:0] w_por;
  logic [1:0]        f_prot;
  logic [2:0]        f_src;
  logic [1:0]        f_posc;

  assign w_gen  = cfg_mem[IDX_GEN];
  assign w_sel  = cfg_mem[IDX_OSCSEL];
  assign w_osc  = cfg_mem[IDX_OSC];
  assign w_por  = cfg_mem[IDX_POR];
  assign f_prot = w_gen[GEN_PROT_LSB +: 2];
  assign f_src  = w_sel[SRC_LSB +: 3];
  assign f_posc = w_osc[POSC_LSB +: 2];

  // [RULE_13] sampled while reset is held, frozen after
  // Mid-run reprogramming cannot disturb clocks until the next reset
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      gen_prot_ff  <= f_prot;
      // [RULE_06] protection level decode
      gen_none_ff  <= (f_prot == PROT_NONE);
      gen_std_ff   <= (f_prot == PROT_STD);
      gen_high_ff  <= ~f_prot[1];
      // [RULE_07] general write gate
      gen_wr_ff    <= w_gen[GEN_WRP_BIT];
      // [RULE_08] two-speed start on fast RC
      two_speed_ff <= w_sel[TWO_SPEED_BIT];
      fast_rc_ff   <= w_sel[TWO_SPEED_BIT];  // Own flop so a stuck start request shows up alone
      // [RULE_09] initial source select
      src_ff       <= f_src;
      src_pll_ff   <= (f_src == NCW_SRC_PRI_PLL);
      // [RULE_10] second oscillator pin role
      second_oscillator_pin_ff      <= w_osc[SECOND_OSCILLATOR_PIN_FN_BIT];
      // [RULE_11] primary oscillator mode
      posc_ff      <= f_posc;
      posc_en_ff   <= (f_posc != NCW_POSC_OFF);
      // [RULE_12] two-wire pin pair, low bit picks alternate
      alt_tw_ff    <= ~w_por[ALT_TW_BIT];
    end
  end

  assign GEN_PROTECT_LEVEL_O  = gen_prot_ff;
  assign GEN_PROT_NONE_O      = gen_none_ff;
  assign GEN_PROT_STANDARD_O  = gen_std_ff;
  assign GEN_PROT_HIGH_O      = gen_high_ff;
  assign GEN_WRITE_ALLOW_O    = gen_wr_ff;
  assign TWO_SPEED_STARTUP_O  = two_speed_ff;
  assign START_ON_FAST_RC_O   = fast_rc_ff;  // Clock block switches once source ready
  assign INIT_CLOCK_SOURCE_O  = src_ff;
  assign INIT_USES_PLL_O      = src_pll_ff;
  assign SECOND_OSCILLATOR_PIN_CLOCK_OUT_O     = second_oscillator_pin_ff;
  assign PRIMARY_OSC_MODE_O   = posc_ff;
  assign PRIMARY_OSC_ENABLE_O = posc_en_ff;
  assign TWO_WIRE_ALT_SEL_O   = alt_tw_ff;

endmodule

// File: rtl/ncw_pkg.sv
// Purpose: Constants for the nonvolatile configuration word bank
// Assumes: Words read through the program-memory table-read path
// Notes:   Word addresses step by two, as program memory does
package ncw_pkg;

  // Word geometry
  localparam int          WORD_W     = 24;
  localparam int          DATA_W     = 16;
  localparam int          ADDR_W     = 24;
  localparam int          NUM_WORDS  = 7;
  localparam int          IDX_W      = 3;

  // Configuration space placement
  localparam logic [23:0] CFG_BASE   = 24'hf80000;
  localparam logic [23:0] ADDR_STEP  = 24'h000002;

  // Word indices
  localparam logic [2:0]  IDX_BOOT   = 3'h0;
  localparam logic [2:0]  IDX_SECURE = 3'h1;
  localparam logic [2:0]  IDX_GEN    = 3'h2;
  localparam logic [2:0]  IDX_OSCSEL = 3'h3;
  localparam logic [2:0]  IDX_OSC    = 3'h4;
  localparam logic [2:0]  IDX_WDOG   = 3'h5;
  localparam logic [2:0]  IDX_POR    = 3'h6;

  // Implemented-bit masks per word
  localparam logic [23:0] MASK_BOOT   = 24'h0000cf;
  localparam logic [23:0] MASK_SECURE = 24'h0000cf;
  localparam logic [23:0] MASK_GEN    = 24'h000007;
  localparam logic [23:0] MASK_OSCSEL = 24'h000087;
  localparam logic [23:0] MASK_OSC    = 24'h0000e7;
  localparam logic [23:0] MASK_WDOG   = 24'h0000ff;
  localparam logic [23:0] MASK_POR    = 24'h0000ff;
  localparam logic [23:0] MASK_CFG    = 24'h00ffff;

  // general_segment_config fields
  localparam int          GEN_WRP_BIT  = 0;
  localparam int          GEN_PROT_LSB = 1;
  // oscillator_source_select fields
  localparam int          SRC_LSB      = 0;
  localparam int          TWO_SPEED_BIT = 7;
  // oscillator_config fields
  localparam int          POSC_LSB     = 0;
  localparam int          SECOND_OSCILLATOR_PIN_FN_BIT  = 2;
  // power_on_config fields
  localparam int          ALT_TW_BIT   = 4;

  // Protection level codes
  localparam logic [1:0]  PROT_NONE    = 2'h3;
  localparam logic [1:0]  PROT_STD     = 2'h2;

  // Primary oscillator modes
  typedef enum logic [1:0] {
    NCW_POSC_EXT_CLK  = 2'b00,
    NCW_POSC_STD_XTAL = 2'b01,
    NCW_POSC_HS_XTAL  = 2'b10,
    NCW_POSC_OFF      = 2'b11
  } ncw_posc_t;

  // Initial clock sources
  typedef enum logic [2:0] {
    NCW_SRC_PRI       = 3'b010,
    NCW_SRC_PRI_PLL   = 3'b011,
    NCW_SRC_SECONDARY = 3'b100,
    NCW_SRC_LOW_RC    = 3'b101,
    NCW_SRC_FRC_DIV16 = 3'b110,
    NCW_SRC_FRC_POST  = 3'b111
  } ncw_src_t;

endpackage

// File: verif/ncw_monitor.sv
// Purpose: Port checker for the config word bank
// Assumes: One clock, sync active-low reset
// Notes:   Nothing is judged while reset is low
`timescale 1ns/1ns
module ncw_monitor
  import ncw_pkg::*;
(
  // Clock, reset and ports watched
  input wire logic              MCLK_I,
  input wire logic              NRST_I,
  input wire logic              RD_EN_I,
  input wire logic [WORD_W-1:0] RD_DATA_O,
  input wire logic              RD_VALID_O,
  input wire logic              ERASE_I,
  input wire logic              WR_DONE_O,
  input wire logic [1:0]        GEN_PROTECT_LEVEL_O,
  input wire logic              GEN_PROT_NONE_O,
  input wire logic              GEN_PROT_STANDARD_O,
  input wire logic              GEN_PROT_HIGH_O,
  input wire logic              TWO_SPEED_STARTUP_O,
  input wire logic              START_ON_FAST_RC_O,
  input wire logic [2:0]        INIT_CLOCK_SOURCE_O,
  input wire logic              INIT_USES_PLL_O,
  input wire logic [1:0]        PRIMARY_OSC_MODE_O,
  input wire logic              PRIMARY_OSC_ENABLE_O,
  input wire logic              TWO_WIRE_ALT_SEL_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  ////////////////////////////////////////////////////////////
  // Read request, then answer with top byte clear
  sequence s_rd_req;
    RD_EN_I;
  endsequence
  sequence s_rd_ans;
    RD_VALID_O && (RD_DATA_O[23:16] == 8'h00);
  endsequence
  property p_read;
    s_rd_req |=> s_rd_ans;
  endproperty
  a_read: assert property (p_read) else $error("read answer late or wide");
  // Valid only ever follows a request
  property p_rd_once;
    !RD_EN_I |=> !RD_VALID_O;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read valid without request");
  property p_erase;
    ERASE_I |=> WR_DONE_O;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not acknowledged");
  property p_none;
    GEN_PROT_NONE_O == (GEN_PROTECT_LEVEL_O == 2'h3);
  endproperty
  a_none: assert property (p_none) else $error("no-protect decode wrong");
  property p_std;
    GEN_PROT_STANDARD_O == (GEN_PROTECT_LEVEL_O == 2'h2);
  endproperty
  a_std: assert property (p_std) else $error("standard-protect decode wrong");
  property p_high;
    GEN_PROT_HIGH_O == !GEN_PROTECT_LEVEL_O[1];
  endproperty
  a_high: assert property (p_high) else $error("high-security decode wrong");
  property p_fastrc;
    START_ON_FAST_RC_O == TWO_SPEED_STARTUP_O;
  endproperty
  a_fastrc: assert property (p_fastrc) else $error("fast RC start mismatch");
  property p_pll;
    INIT_USES_PLL_O == (INIT_CLOCK_SOURCE_O == 3'h3);
  endproperty
  a_pll: assert property (p_pll) else $error("PLL source decode wrong");
  property p_posc;
    PRIMARY_OSC_ENABLE_O == (PRIMARY_OSC_MODE_O != 2'h3);
  endproperty
  a_posc: assert property (p_posc) else $error("primary enable decode wrong");
  // Settings frozen once out of reset
  property p_hold;
    NRST_I && $past(NRST_I) |-> $stable({GEN_PROTECT_LEVEL_O, INIT_CLOCK_SOURCE_O, PRIMARY_OSC_MODE_O,
                                         TWO_SPEED_STARTUP_O, TWO_WIRE_ALT_SEL_O});
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved outside reset");
endmodule
bind ncw_config_bank ncw_monitor u_mon (.MCLK_I, .NRST_I, .RD_EN_I, .RD_DATA_O, .RD_VALID_O, .ERASE_I, .WR_DONE_O,
  .GEN_PROTECT_LEVEL_O, .GEN_PROT_NONE_O, .GEN_PROT_STANDARD_O, .GEN_PROT_HIGH_O, .TWO_SPEED_STARTUP_O,
  .START_ON_FAST_RC_O,
  .INIT_CLOCK_SOURCE_O, .INIT_USES_PLL_O, .PRIMARY_OSC_MODE_O, .PRIMARY_OSC_ENABLE_O, .TWO_WIRE_ALT_SEL_O);

// File: verif/ncw_programmer.sv
// Purpose: Programmer model on the write port
// Assumes: Drives at the falling edge
// Notes:   Idle address and data lines show inverted last value
`timescale 1ns/1ns
module ncw_programmer
  import ncw_pkg::*;
(
  // Clock and answer
  input  wire logic              clk_i,
  input  wire logic              done_i,
  // Request
  output logic                   wr_en_o,
  output logic                   erase_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [WORD_W-1:0]      wr_data_o
);
  initial
  begin
    wr_en_o = 1'b0;
    erase_o = 1'b0;
    wr_addr_o = 24'h0;
    wr_data_o = 24'h0;
  end
  // one word or erase per pulse
  task automatic pulse(input logic ers, input logic [2:0] idx, input logic [23:0] dat, output logic ok);
    int n;
    @(negedge clk_i);
    wr_en_o = !ers;
    erase_o = ers;
    wr_addr_o = CFG_BASE + ADDR_STEP * idx;
    wr_data_o = dat;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    erase_o = 1'b0;
    wr_addr_o = ~wr_addr_o;
    wr_data_o = ~wr_data_o;
    for (n = 0; n < 3 && done_i !== 1'b1; n++)
      @(negedge clk_i);
    ok = (n < 3);
  endtask
endmodule

// File: verif/test_nonvolatile_config_word_bank.sv
// Purpose: Self-checking bench for the config bank
// Assumes: Storage powers up erased
// Notes:   Every field code is loaded by a reset pulse
`timescale 1ns/1ns
module test_nonvolatile_config_word_bank
  import ncw_pkg::*;
;
  logic MCLK_I = 0, NRST_I = 0, RD_EN_I = 0, WR_EN_I, ERASE_I, RD_VALID_O, WR_DONE_O, ok;
  logic GEN_PROT_NONE_O, GEN_PROT_STANDARD_O, GEN_PROT_HIGH_O, GEN_WRITE_ALLOW_O, TWO_SPEED_STARTUP_O;
  logic START_ON_FAST_RC_O, INIT_USES_PLL_O, SECOND_OSCILLATOR_PIN_CLOCK_OUT_O, PRIMARY_OSC_ENABLE_O, TWO_WIRE_ALT_SEL_O;
  logic [1:0] GEN_PROTECT_LEVEL_O, PRIMARY_OSC_MODE_O;
  logic [2:0] INIT_CLOCK_SOURCE_O, i, prev;
  logic [23:0] RD_ADDR_I = 0, WR_ADDR_I, WR_DATA_I, RD_DATA_O;
  logic [23:0] m [7] = '{MASK_BOOT, MASK_SECURE, MASK_GEN, MASK_OSCSEL, MASK_OSC, MASK_WDOG, MASK_POR};
  int miscompares = 0, check_count = 0, k;
  ncw_config_bank u_dut (.MCLK_I, .NRST_I, .RD_EN_I, .RD_ADDR_I, .RD_DATA_O, .RD_VALID_O, .WR_EN_I, .WR_ADDR_I,
                         .WR_DATA_I, .ERASE_I, .WR_DONE_O, .GEN_PROTECT_LEVEL_O, .GEN_PROT_NONE_O,
                         .GEN_PROT_STANDARD_O, .GEN_PROT_HIGH_O, .GEN_WRITE_ALLOW_O, .TWO_SPEED_STARTUP_O,
                         .START_ON_FAST_RC_O, .INIT_CLOCK_SOURCE_O, .INIT_USES_PLL_O, .SECOND_OSCILLATOR_PIN_CLOCK_OUT_O,
                         .PRIMARY_OSC_MODE_O, .PRIMARY_OSC_ENABLE_O, .TWO_WIRE_ALT_SEL_O);
  ncw_programmer u_prog (.clk_i(MCLK_I), .done_i(WR_DONE_O), .wr_en_o(WR_EN_I), .erase_o(ERASE_I),
                         .wr_addr_o(WR_ADDR_I), .wr_data_o(WR_DATA_I));
  always #4 MCLK_I = ~MCLK_I;
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One table read, answer taken in the next cycle
  task automatic rd(input logic [2:0] idx, input logic [23:0] exp);
    int n;
    @(negedge MCLK_I);
    RD_EN_I = 1'b1;
    RD_ADDR_I = CFG_BASE + ADDR_STEP * idx;
    @(negedge MCLK_I);
    RD_EN_I = 1'b0;
    RD_ADDR_I = ~RD_ADDR_I;
    for (n = 0; n < 3 && RD_VALID_O !== 1'b1; n++)
      @(negedge MCLK_I);
    if (n == 3)
    begin
      miscompares++;
      print_verdict();
    end
    else
      chk(RD_DATA_O, exp, "read");
  endtask
  // One programmer call; a missing done ends the run
  task automatic prog(input logic ers, input logic [2:0] idx, input logic [23:0] dat);
    u_prog.pulse(ers, idx, dat, ok);
    chk(24'(ok), 24'h1, "done");
    if (ok !== 1'b1)
      print_verdict();
  endtask
  task automatic rst(input int n);
    @(negedge MCLK_I);
    NRST_I = 1'b0;
    repeat (n) @(negedge MCLK_I);
    NRST_I = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst(20);
    for (k = 0; k < 7; k++)
      rd(k[2:0], m[k]);
    rd(3'h7, 24'h0);
    prev = 3'h7;
    for (k = 0; k < 8; k++)
    begin
      i = k[2:0];
      prog(1'b0, IDX_GEN, {16'hff00, 5'h1f, i});
      prog(1'b0, IDX_OSCSEL, {16'h5a00, i[0], 4'hf, i});
      prog(1'b0, IDX_OSC, {16'h0, 3'h0, 2'h3, i});
      prog(1'b0, IDX_POR, {19'h0, i[0], 4'h0});
      rd(IDX_GEN, {21'h0, i});
      rd(IDX_OSCSEL, {16'h0, i[0], 4'h0, i});
      chk(24'(INIT_CLOCK_SOURCE_O), 24'(prev), "held source");
      rst(2);
      prev = i;
      chk({GEN_PROTECT_LEVEL_O, GEN_PROT_NONE_O, GEN_PROT_STANDARD_O, GEN_PROT_HIGH_O},
          {i[2:1], i[2:1] == 2'h3, i[2:1] == 2'h2, ~i[2]}, "protect");
      chk(24'(GEN_WRITE_ALLOW_O), 24'(i[0]), "write allow");
      chk({TWO_SPEED_STARTUP_O, START_ON_FAST_RC_O}, {2{i[0]}}, "two speed");
      chk({INIT_CLOCK_SOURCE_O, INIT_USES_PLL_O}, {i, i == 3'h3}, "source");
      chk(24'(SECOND_OSCILLATOR_PIN_CLOCK_OUT_O), 24'(i[2]), "second_oscillator_pin pin");
      chk({PRIMARY_OSC_MODE_O, PRIMARY_OSC_ENABLE_O}, {i[1:0], i[1:0] != 2'h3}, "primary");
      chk(24'(TWO_WIRE_ALT_SEL_O), {23'h0, !i[0]}, "two wire");
    end
    prog(1'b1, 3'h0, 24'h0);
    rd(IDX_OSC, MASK_OSC);
    print_verdict();
  end
endmodule
